// file: hdl/core_addr_pkg.sv
// shared types and constants for the storage address register and write decode
package core_addr_pkg;

    // one address byte: bits numbered 0 (high order) to 7, plus its parity bit
    typedef struct packed {
        logic [0:7] bits;
        logic       par;
    } addr_byte_s;

    // two-byte storage address as carried on the 18-bit assembler bus
    typedef struct packed {
        addr_byte_s upper;
        addr_byte_s lower;
    } addr_word_s;

    // zero address with odd parity in each byte
    localparam addr_byte_s BYTE_RST = '{bits: 8'h00, par: 1'b1};
    localparam addr_word_s WORD_RST = '{upper: BYTE_RST, lower: BYTE_RST};

    // assembler bus sources (six register groups, then console and next address)
    localparam int         NUM_REG_SRC = 6;
    localparam logic [2:0] SRC_IJ      = 3'h0;
    localparam logic [2:0] SRC_UV      = 3'h1;
    localparam logic [2:0] SRC_LT      = 3'h2;
    localparam logic [2:0] SRC_GUV     = 3'h3;
    localparam logic [2:0] SRC_HUV     = 3'h4;
    localparam logic [2:0] SRC_EXTRA   = 3'h5;
    localparam logic [2:0] SRC_CONSOLE = 3'h6;
    localparam logic [2:0] SRC_NEXT    = 3'h7;

    // field positions within the upper and lower address bytes
    localparam int UB_UNIT   = 0;
    localparam int UB_X_TERM = 1;
    localparam int UB_BLOCK  = 2;
    localparam int LB_HALF   = 2;

    // decode indices of the groups named in the write example
    localparam logic [2:0] Y_DRV_3072_4095 = 3'h3;
    localparam logic [3:0] Y_GATE_384_447  = 4'h9;
    localparam logic [2:0] INH_BLK3_HALF_A = 3'h4;

    // storage clock timing pulses of the write cycle
    typedef struct packed {
        logic write2;
        logic phase_write_a;
        logic inhibit_pulse;
    } timing_s;

    // write-cycle select outputs towards the drive and inhibit circuits
    typedef struct packed {
        logic        y_write_timing_pulse;
        logic [7:0]  y_driver_sel;
        logic [15:0] y_gate_sel;
        logic [1:0]  x_term_sel;
        logic [1:0]  y_term_sel;
        logic [7:0]  inhibit_group_sel;
        logic [8:0]  inhibit_drive;
    } decode_s;

    // read/write interlock states
    typedef enum logic [1:0] {
        IL_ALLOW_READ  = 2'b01,
        IL_ALLOW_WRITE = 2'b10
    } interlock_e;

endpackage

// file: hdl/addr_parity_check.sv
// exclusive-or parity checker for one nine-bit address byte
`timescale 1ns/1ps
module addr_parity_check
    import core_addr_pkg::*;
(
    input  wire addr_byte_s byte_in,
    output logic            even_err
);

    // an even count of ones over the nine bits is an error
    assign even_err = ~(^{byte_in.bits, byte_in.par}); // RULE_16 RULE_20

endmodule

// file: hdl/write_select_decode.sv
// combinational x/y terminator, y drive and inhibit group decode for a write
`timescale 1ns/1ps
module write_select_decode
    import core_addr_pkg::*;
(
    input  wire addr_word_s addr,
    input  wire timing_s    timing,
    input  wire logic       use_main_mem,
    input  wire logic [8:0] store_data,
    output decode_s         dec
);

    logic       ywt;
    logic [2:0] ydrv_idx;
    logic [3:0] ygate_idx;
    logic [2:0] inh_idx;

    // y write timing pulse and its driver group
    assign ywt       = ~addr.upper.bits[UB_BLOCK] & timing.write2 & use_main_mem; // RULE_01
    assign ydrv_idx  = addr.upper.bits[3:5];
    assign ygate_idx = {addr.lower.bits[0], addr.lower.bits[1],
                        addr.upper.bits[6], addr.upper.bits[7]};
    // block from upper bits 1 and 2, half from lower bit 2
    assign inh_idx   = {addr.upper.bits[UB_X_TERM], addr.upper.bits[UB_BLOCK],
                        addr.lower.bits[LB_HALF]}; // RULE_08

    always_comb
    begin
        dec                      = '0;
        dec.y_write_timing_pulse = ywt;
        dec.y_driver_sel[ydrv_idx] = ywt; // RULE_02
        dec.y_gate_sel[ygate_idx]  = 1'b1; // RULE_03
        // x terminator steered by upper bit 1, y terminator by its inverse of bit 2
        dec.x_term_sel[addr.upper.bits[UB_X_TERM]] = timing.phase_write_a; // RULE_04
        dec.y_term_sel[~addr.upper.bits[UB_BLOCK]] = timing.phase_write_a; // RULE_05
        // only one group of nine, and only at inhibit time
        dec.inhibit_group_sel[inh_idx] = timing.inhibit_pulse; // RULE_06 RULE_09
        // a stored one keeps its driver off
        dec.inhibit_drive = timing.inhibit_pulse ? ~store_data : 9'h000; // RULE_07
    end

endmodule

// file: hdl/core_addr_register.sv
// storage address registers, parity check, read/write interlock and write decode
//
// Overview of operation
// RULE_01: y write pulse needs upper bit 2 zero, write 2 pulse and main memory.
// RULE_02: y driver group needs upper bit 3 zero, bits 4, 5 one, y pulse.
// RULE_03: y gate needs lower bit 1 zero, lower bit 0 one, bit 7 one, bit 6 zero.
// RULE_04: x terminator enabled by phase write a, steered by upper bit 1.
// RULE_05: y terminator enabled by phase write a, steered by inverse upper bit 2.
// RULE_06: exactly one group of nine inhibit drivers may be active per write.
// RULE_07: inhibit driver turns on only where the stored data bit is zero.
// RULE_08: upper bits 2 and 1 pick block, lower bit 2 picks half.
// RULE_09: third block first half select: upper 2 zero, 1 one, lower 2 zero, inhibit.
// RULE_10: address register is two nine-bit latches, eight bits plus parity each.
// RULE_11: address register outputs drive addressing continuously, no output gating.
// RULE_12: register loads from 18-bit assembler bus with seven sources; the code muxes eight (six groups, console, next).
// RULE_13: clock running, load only at t1 of a read cycle, never on write.
// RULE_14: clock stopped, register loads from the console switches.
// RULE_15: second register loads with same timing, and from console on manual store.
// RULE_16: per-byte parity checkers; even parity sets the machine check latch.
// RULE_17: parity error is blocked while local storage is addressed.
// RULE_18: first storage clock starts only when upper bit 0 is zero.
// RULE_19: interlock set by read, cleared by write, gates loads and calls.
// RULE_20: each byte must hold odd parity over its nine bits.
`timescale 1ns/1ps
module core_addr_register
    import core_addr_pkg::*;
(
    input  wire logic                         core_clk,
    input  wire logic                         reset_n,
    input  wire logic                         clock_running,
    input  wire logic                         t1_pulse,
    input  wire logic                         read_cycle,
    input  wire logic [2:0]                   asm_sel,
    input  wire addr_word_s [NUM_REG_SRC-1:0] asm_src,
    input  wire addr_word_s                   next_addr,
    input  wire addr_word_s                   console_sw,
    input  wire logic                         console_load,
    input  wire logic                         manual_op,
    input  wire logic                         second_unit_fitted,
    input  wire logic                         read_call_req,
    input  wire logic                         write_call_req,
    input  wire logic                         use_main_mem,
    input  wire logic                         mc_reset,
    input  wire timing_s                      timing,
    input  wire logic [8:0]                   store_data,
    output addr_word_s                        storage_address_register,
    output addr_word_s                        second_address_register,
    output logic                              read_call,
    output logic                              write_call,
    output logic                              start_clk1,
    output logic                              start_clk2,
    output logic                              addr_check_line,
    output logic                              machine_check_register,
    output decode_s                           write_select
);

    // panel inputs pass two flip-flops
    typedef struct packed {
        addr_word_s sw;
        logic       running;
        logic       load;
        logic       manual;
    } panel_s;

    typedef struct packed {
        panel_s     sync1;
        panel_s     sync2;
        logic       load_seen;
        addr_word_s addr1;
        addr_word_s addr2;
        interlock_e il;
        logic       read_call;
        logic       write_call;
        logic       start_clk1;
        logic       start_clk2;
        logic       check_line;
        logic       mc_check;
        decode_s    dec;
    } state_s;

    state_s     st_q;
    state_s     st_d;
    addr_word_s bus;
    logic [3:0] byte_err;
    logic       any_err;
    logic       t1_load;
    logic       console_edge;
    logic       read_ok;
    logic       write_ok;
    decode_s    dec_c;

    // assembler bus multiplexer over the eight sources
    function automatic addr_word_s asm_mux(input logic [2:0] sel,
                                           input addr_word_s [NUM_REG_SRC-1:0] src,
                                           input addr_word_s nxt,
                                           input addr_word_s cons);
        addr_word_s r;
        case (sel)
            SRC_CONSOLE: r = cons;
            SRC_NEXT:    r = nxt;
            default:     r = src[sel];
        endcase
        return r;
    endfunction

    assign bus = asm_mux(asm_sel, asm_src, next_addr, st_q.sync2.sw); // RULE_12

    // parity checkers on all four address bytes
    addr_parity_check u_chk_m1 (.byte_in(st_q.addr1.upper), .even_err(byte_err[0]));
    addr_parity_check u_chk_n1 (.byte_in(st_q.addr1.lower), .even_err(byte_err[1]));
    addr_parity_check u_chk_m2 (.byte_in(st_q.addr2.upper), .even_err(byte_err[2]));
    addr_parity_check u_chk_n2 (.byte_in(st_q.addr2.lower), .even_err(byte_err[3]));

    assign any_err = |byte_err; // RULE_16

    // write decode from the held address
    write_select_decode u_dec (
        .addr        (st_q.addr1),
        .timing      (timing),
        .use_main_mem(use_main_mem),
        .store_data  (store_data),
        .dec         (dec_c)
    );

    // load and call qualification
    assign t1_load      = st_q.sync2.running & t1_pulse & read_cycle
                          & (st_q.il == IL_ALLOW_READ); // RULE_13 RULE_19
    assign console_edge = st_q.sync2.load & ~st_q.load_seen;
    assign read_ok      = read_call_req & (st_q.il == IL_ALLOW_READ); // RULE_19
    assign write_ok     = write_call_req & (st_q.il == IL_ALLOW_WRITE); // RULE_19

    // next state
    always_comb
    begin
        st_d            = st_q;
        st_d.sync1      = '{sw: console_sw, running: clock_running,
                            load: console_load, manual: manual_op};
        st_d.sync2      = st_q.sync1;
        st_d.load_seen  = st_q.sync2.load;
        st_d.read_call  = 1'b0;
        st_d.write_call = 1'b0;
        st_d.start_clk1 = 1'b0;
        st_d.start_clk2 = 1'b0;
        // both byte latches load together; outputs are never gated
        if (t1_load)
        begin
            st_d.addr1 = bus; // RULE_10 RULE_11 RULE_13
        end
        else if (console_edge && !st_q.sync2.running)
        begin
            st_d.addr1 = st_q.sync2.sw; // RULE_14
        end
        if (second_unit_fitted)
        begin
            if (t1_load)
            begin
                st_d.addr2 = bus; // RULE_15
            end
            else if (console_edge && (st_q.sync2.manual || !st_q.sync2.running))
            begin
                st_d.addr2 = st_q.sync2.sw; // RULE_15
            end
        end
        // reads and writes alternate through the interlock
        case (st_q.il)
            IL_ALLOW_READ:
            begin
                if (read_ok)
                begin
                    st_d.il        = IL_ALLOW_WRITE; // RULE_19
                    st_d.read_call = 1'b1;
                end
            end
            IL_ALLOW_WRITE:
            begin
                if (write_ok)
                begin
                    st_d.il         = IL_ALLOW_READ; // RULE_19
                    st_d.write_call = 1'b1;
                end
            end
            default:
            begin
                st_d.il = IL_ALLOW_READ;
            end
        endcase
        // unit clock chosen by the high-order address bit
        if (read_ok || write_ok)
        begin
            st_d.start_clk1 = ~st_q.addr1.upper.bits[UB_UNIT]; // RULE_18
            st_d.start_clk2 = st_q.addr1.upper.bits[UB_UNIT] & second_unit_fitted;
        end
        // check line blocked for local storage; set wins over clear
        st_d.check_line = any_err & use_main_mem; // RULE_16 RULE_17
        if (mc_reset)
        begin
            st_d.mc_check = 1'b0;
        end
        if (st_d.check_line)
        begin
            st_d.mc_check = 1'b1; // RULE_16
        end
        st_d.dec = dec_c;
    end

    // state register
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            st_q       <= '0;
            st_q.addr1 <= WORD_RST;
            st_q.addr2 <= WORD_RST;
            st_q.il    <= IL_ALLOW_READ;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state register
    assign storage_address_register = st_q.addr1;
    assign second_address_register  = st_q.addr2;
    assign read_call                = st_q.read_call;
    assign write_call               = st_q.write_call;
    assign start_clk1               = st_q.start_clk1;
    assign start_clk2               = st_q.start_clk2;
    assign addr_check_line          = st_q.check_line;
    assign machine_check_register   = st_q.mc_check;
    assign write_select             = st_q.dec;

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_read_taken;
        read_call_req && st_q.il == IL_ALLOW_READ;
    endsequence

    sequence s_read_done;
        read_call && st_q.il == IL_ALLOW_WRITE;
    endsequence

    sequence s_write_taken;
        write_call_req && st_q.il == IL_ALLOW_WRITE;
    endsequence

    a_read_sets_lock: // RULE_19
    assert property (s_read_taken |=> s_read_done)
        else $error("read call did not set the interlock");

    a_write_clears_lock: // RULE_19
    assert property (s_write_taken |=> write_call && st_q.il == IL_ALLOW_READ)
        else $error("write call did not clear the interlock");

    a_double_read_blocked: // RULE_19
    assert property (read_call |=> !read_call)
        else $error("two reads without an intervening write");

    a_load_at_t1: // RULE_13
    assert property (t1_load |=> storage_address_register == $past(bus))
        else $error("address not loaded from the bus at t1");

    a_hold_in_write: // RULE_13
    assert property (st_q.il == IL_ALLOW_WRITE && st_q.sync2.running
                     |=> $stable(storage_address_register))
        else $error("address changed between read and write");

    a_clock_unit_bit: // RULE_18
    assert property (start_clk1 |-> !$past(storage_address_register.upper.bits[UB_UNIT]))
        else $error("first unit clock started with high address bit set");

    a_check_latched: // RULE_16
    assert property (any_err && use_main_mem |=> addr_check_line ##1 machine_check_register)
        else $error("address parity error not latched");

    a_check_blocked: // RULE_17
    assert property (!use_main_mem |=> !addr_check_line)
        else $error("parity error passed while local storage addressed");

    a_ywt_cause: // RULE_01
    assert property (write_select.y_write_timing_pulse |->
                     $past(timing.write2 && use_main_mem
                           && !storage_address_register.upper.bits[UB_BLOCK]))
        else $error("y write pulse without its conditions");

    a_inhibit_one_group: // RULE_06
    assert property ($onehot0(write_select.inhibit_group_sel))
        else $error("more than one inhibit group active");

    a_inhibit_data: // RULE_07
    assert property ((write_select.inhibit_drive & $past(store_data)) == 9'h000)
        else $error("inhibit driver on where a one is stored");

    a_blk3_half_a: // RULE_09
    assert property (timing.inhibit_pulse && st_q.addr1.upper.bits[1:2] == 2'b10
                     && !st_q.addr1.lower.bits[LB_HALF]
                     |=> write_select.inhibit_group_sel[INH_BLK3_HALF_A])
        else $error("third block first half not selected");

    a_ydrv_group: // RULE_02
    assert property (write_select.y_driver_sel[Y_DRV_3072_4095] |->
                     $past(timing.write2 && use_main_mem
                           && storage_address_register.upper.bits[2:5] == 4'b0011))
        else $error("y driver group selected without its address bits");

    a_ygate_group: // RULE_03
    assert property (write_select.y_gate_sel[Y_GATE_384_447] |->
                     $past(storage_address_register.lower.bits[0:1] == 2'b10
                           && storage_address_register.upper.bits[6:7] == 2'b01))
        else $error("y gate selected without its address bits");

endmodule

// file: bench/storage_drive_model.sv
// storage clock model: write timing pulses once a write cycle starts
`timescale 1ns/1ps
module storage_drive_model
    import core_addr_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic start_clk,
    input  wire logic write_call,
    input  wire logic slow,
    output timing_s   timing
);
    logic [2:0] step_q;

    // steps 1-2 drive, 3-4 inhibit; a slow start idles through 5-7 first
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            step_q <= 3'h0;
        else if (start_clk && write_call)
            step_q <= slow ? 3'h5 : 3'h1;
        else if (step_q == 3'h4 || step_q == 3'h0)
            step_q <= 3'h0;
        else
            step_q <= (step_q == 3'h7) ? 3'h1 : step_q + 3'h1;
    end

    // pulses are low whenever the storage clock is idle
    always_comb
    begin
        timing.write2        = (step_q == 3'h1) || (step_q == 3'h2);
        timing.phase_write_a = timing.write2;
        timing.inhibit_pulse = (step_q == 3'h3) || (step_q == 3'h4);
    end
endmodule

// file: bench/core_addr_register_tb.sv
// self-checking bench for the storage address register and write decode
`timescale 1ns/1ps
module core_addr_register_tb
    import core_addr_pkg::*;
;
    logic core_clk, reset_n, clock_running, t1_pulse, read_cycle, console_load;
    logic manual_op, second_unit_fitted, read_call_req, write_call_req, slow;
    logic use_main_mem, mc_reset, read_call, write_call, start_clk1, start_clk2;
    logic addr_check_line, machine_check_register;
    logic [2:0] asm_sel;
    logic [8:0] store_data;
    addr_word_s [NUM_REG_SRC-1:0] asm_src;
    addr_word_s next_addr, console_sw, storage_address_register, second_address_register;
    timing_s    timing;
    decode_s    write_select;
    int         failures, compares, cycles;

    core_addr_register uut (.core_clk, .reset_n, .clock_running, .t1_pulse, .read_cycle,
        .asm_sel, .asm_src, .next_addr, .console_sw, .console_load, .manual_op,
        .second_unit_fitted, .read_call_req, .write_call_req, .use_main_mem, .mc_reset,
        .timing, .store_data, .storage_address_register, .second_address_register,
        .read_call, .write_call, .start_clk1, .start_clk2, .addr_check_line,
        .machine_check_register, .write_select);

    storage_drive_model far_side (.core_clk, .reset_n, .start_clk(start_clk1 | start_clk2),
        .write_call, .slow, .timing);

    // free-running 50 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // hang guard
    always @(posedge core_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            failures = failures + 1;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // address word with odd parity in each byte
    function automatic addr_word_s mk(input logic [15:0] v);
        mk.upper = '{bits: v[15:8], par: ~^v[15:8]};
        mk.lower = '{bits: v[7:0], par: ~^v[7:0]};
    endfunction

    // present a source at t1, then compare both registers
    task automatic ld(input logic [2:0] sel, input addr_word_s w, input logic rc,
                      input addr_word_s exp);
        @(posedge core_clk);
        if (sel == 3'h7)
            next_addr <= w;
        else if (sel != 3'h6)
            asm_src[sel] <= w;
        asm_sel <= sel;
        t1_pulse <= 1'b1;
        read_cycle <= rc;
        @(posedge core_clk);
        t1_pulse <= 1'b0;
        read_cycle <= 1'b0;
        repeat (2) @(negedge core_clk);
        check(storage_address_register, exp);
        check(second_address_register, exp);
    endtask

    task automatic req(input logic wr);
        @(posedge core_clk);
        write_call_req <= wr;
        read_call_req <= !wr;
        @(posedge core_clk);
        write_call_req <= 1'b0;
        read_call_req <= 1'b0;
    endtask

    // one request, count the single-cycle answers that follow
    task automatic call(input logic wr, input logic [1:0] e_call, e_s1, e_s2);
        logic [1:0] nc, n1, n2;
        nc = 2'h0;
        n1 = 2'h0;
        n2 = 2'h0;
        req(wr);
        repeat (3)
        begin
            @(negedge core_clk);
            nc = nc + {1'b0, wr ? write_call : read_call};
            n1 = n1 + {1'b0, start_clk1};
            n2 = n2 + {1'b0, start_clk2};
        end
        check(nc, e_call);
        check(n1, e_s1);
        check(n2, e_s2);
    endtask

    // full read then write cycle, judging the registered select outputs
    task automatic wr_check(input logic [15:0] v, input logic umm, input logic [8:0] d,
                            input logic slw);
        addr_byte_s ub, lb;
        addr_word_s w;
        logic       e;
        int         n;
        w = mk(v);
        ub = w.upper;
        lb = w.lower;
        @(posedge core_clk);
        use_main_mem <= umm;
        store_data <= d;
        slow <= slw;
        ld(3'h7, mk(v), 1'b1, mk(v));
        call(1'b0, 2'h1, {1'b0, !ub.bits[0]}, {1'b0, ub.bits[0]});
        req(1'b1);
        for (n = 0; n < 12 && timing.write2 !== 1'b1; n++)
            @(negedge core_clk);
        @(negedge core_clk);
        e = !ub.bits[2] && umm;
        check(write_select.y_write_timing_pulse, e);
        check(write_select.y_driver_sel,
              e ? 8'h01 << {ub.bits[3], ub.bits[4], ub.bits[5]} : 8'h00);
        if (e)
            check(write_select.y_gate_sel,
                  16'h0001 << {lb.bits[0], lb.bits[1], ub.bits[6], ub.bits[7]});
        check(write_select.x_term_sel, 2'h1 << ub.bits[1]);
        check(write_select.y_term_sel, 2'h1 << !ub.bits[2]);
        repeat (2) @(negedge core_clk);
        if (umm)
            check(write_select.inhibit_group_sel,
                  8'h01 << {ub.bits[1], ub.bits[2], lb.bits[2]});
        check(write_select.inhibit_drive, 9'(~d));
        check(write_select.x_term_sel, 2'h0);
    endtask

    task automatic s_sources();
        addr_word_s w;
        for (int i = 0; i < 8; i++)
        begin
            w = mk(16'(i * 16'h2469 + 16'h0f0f));
            if (i != 6)
                ld(3'(i), w, 1'b1, w);
        end
    endtask

    task automatic s_interlock();
        ld(3'h2, mk(16'h0a0b), 1'b1, mk(16'h0a0b));
        ld(3'h3, mk(16'h7777), 1'b0, mk(16'h0a0b));
        call(1'b0, 2'h1, 2'h1, 2'h0);
        ld(3'h4, mk(16'h5555), 1'b1, mk(16'h0a0b));
        call(1'b0, 2'h0, 2'h0, 2'h0);
        call(1'b1, 2'h1, 2'h1, 2'h0);
        call(1'b1, 2'h0, 2'h0, 2'h0);
        ld(3'h5, mk(16'h8a0b), 1'b1, mk(16'h8a0b));
        call(1'b0, 2'h1, 2'h0, 2'h1);
        call(1'b1, 2'h1, 2'h0, 2'h1);
        // without the second unit its clock never starts
        @(posedge core_clk);
        second_unit_fitted <= 1'b0;
        call(1'b0, 2'h1, 2'h0, 2'h0);
        call(1'b1, 2'h1, 2'h0, 2'h0);
        @(posedge core_clk);
        second_unit_fitted <= 1'b1;
    endtask

    // bad upper then bad lower parity, with and without main storage
    task automatic s_parity();
        addr_word_s w;
        w = mk(16'h3c5a);
        w.upper.par = !w.upper.par;
        ld(3'h0, w, 1'b1, w);
        repeat (2) @(negedge core_clk);
        check(addr_check_line, 1'b1);
        check(machine_check_register, 1'b1);
        @(posedge core_clk);
        use_main_mem <= 1'b0;
        repeat (3) @(negedge core_clk);
        check(addr_check_line, 1'b0);
        @(posedge core_clk);
        mc_reset <= 1'b1;
        @(posedge core_clk);
        mc_reset <= 1'b0;
        repeat (2) @(negedge core_clk);
        check(machine_check_register, 1'b0);
        w = mk(16'h3c5a);
        w.lower.par = !w.lower.par;
        ld(3'h1, w, 1'b1, w);
        @(posedge core_clk);
        use_main_mem <= 1'b1;
        repeat (3) @(negedge core_clk);
        check(addr_check_line, 1'b1);
        ld(3'h1, mk(16'h3c5a), 1'b1, mk(16'h3c5a));
        @(posedge core_clk);
        mc_reset <= 1'b1;
        @(posedge core_clk);
        mc_reset <= 1'b0;
        repeat (2) @(negedge core_clk);
        check(addr_check_line, 1'b0);
        check(machine_check_register, 1'b0);
    endtask

    // clock stopped: load key takes the console switches
    task automatic s_console();
        int n;
        @(posedge core_clk);
        clock_running <= 1'b0;
        manual_op <= 1'b1;
        console_sw <= mk(16'h1234);
        repeat (4) @(posedge core_clk);
        console_load <= 1'b1;
        for (n = 0; n < 8 && storage_address_register !== mk(16'h1234); n++)
            @(negedge core_clk);
        check(storage_address_register, mk(16'h1234));
        check(second_address_register, mk(16'h1234));
        @(posedge core_clk);
        console_load <= 1'b0;
        clock_running <= 1'b1;
        manual_op <= 1'b0;
        console_sw <= mk(16'h2468);
        repeat (4) @(posedge core_clk);
        // clock running: switches reach the register only through the bus
        ld(3'h6, mk(16'h2468), 1'b1, mk(16'h2468));
    endtask

    initial
    begin
        {failures, compares, cycles} = '0;
        {reset_n, t1_pulse, read_cycle, console_load, manual_op, slow} = '0;
        {read_call_req, write_call_req, mc_reset, asm_sel, store_data} = '0;
        {clock_running, second_unit_fitted, use_main_mem} = 3'h7;
        asm_src = '0;
        next_addr = '0;
        console_sw = '0;
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(negedge core_clk);
        check(storage_address_register, WORD_RST);
        check(second_address_register, WORD_RST);
        check(machine_check_register, 1'b0);
        check(write_select.y_gate_sel, 16'h0001);
        check({write_select.y_write_timing_pulse, write_select.inhibit_group_sel,
               write_select.inhibit_drive}, '0);
        s_sources();
        s_interlock();
        s_parity();
        s_console();
        wr_check(16'h4d8b, 1'b1, 9'h1a5, 1'b0);
        wr_check(16'hb274, 1'b1, 9'h05a, 1'b1);
        wr_check(16'h6f44, 1'b1, 9'h100, 1'b0);
        wr_check(16'h4d8b, 1'b0, 9'h0ff, 1'b0);
        tally_and_finish();
    end
endmodule
